// ### src/por_consts.svh
// Constants for the power-on reset sequencer and its host end.
`ifndef POR_CONSTS_SVH
`define POR_CONSTS_SVH
`define POR_MIN_HOLD 16
`define CFG_CYCLES 1024
`define PLL_LOCK_REF 800
`define DLL_LOCK_CYCLES 3073
`define HRST_EXTRA 512
`define SRST_LAG 3
`define EXT_GRACE 3
`define BYTE_GAP 4
`define CFG_BYTES 4
`define DLL_DIS_BIT 0
`define CLOCK_MODE_HIGH_FIELD_MSB 31
`define CLOCK_MODE_HIGH_FIELD_LSB 28
`define BOOT_EXT 2'h0
`define BOOT_HOST 2'h1
`define REG_CTRL 8'h00
`define REG_STRAP 8'h04
`define REG_WORD 8'h08
`define REG_STAT 8'h0c
`define CTRL_START 0
`define CTRL_HARD 1
`define CTRL_SOFT 2
`define STRAP_RESET 8'h00
`endif

// ### src/por_pkg.sv
// Types shared by both ends of the power-on reset link.
package por_pkg;
	typedef enum logic [2:0] {S_POR, S_CONFIG, S_HOST_WAIT, S_PLL_WAIT, S_DLL_LOCK, S_HRST_HOLD, S_SRST_HOLD,
		S_RUN} dev_state_t;
	typedef enum logic [1:0] {H_IDLE, H_POR, H_WRITE, H_DONE} host_state_t;
	typedef struct packed {
		logic [20:0] s1;
		logic [20:0] s2;
		dev_state_t state;
		logic [11:0] cnt;
		logic por_prev;
		logic tog_prev;
		logic cap_role;
		logic cap_dbg;
		logic cap_hpe;
		logic [1:0] cap_boot;
		logic [2:0] nbytes;
		logic written;
		logic [31:0] word;
		logic int_por_n;
		logic pll_start;
		logic clocks_enable;
		logic hard_drv;
		logic soft_drv;
		logic cfg_master;
		logic debug_mode;
		logic host_port_en;
		logic bus_32bit;
		logic [1:0] boot_src;
		logic boot_reserved;
		logic [6:0] clock_ratio;
		logic ext_hard_seen;
		logic ext_soft_seen;
	} dev_regs_t;
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		host_state_t state;
		logic [3:0] cnt;
		logic [2:0] nbytes;
		logic por_n;
		logic tog;
		logic [7:0] wr_byte;
		logic [7:0] strap;
		logic [31:0] word;
		logic hard_req;
		logic soft_req;
		logic done;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} host_regs_t;
endpackage : por_pkg

// ### src/por_link_if.sv
// Pin-level link between the reset sequencer and its external reset source and host.
`timescale 1ns/1ps
interface por_link_if;
	logic power_on_reset_n;
	logic cfg_role_select;
	logic debug_request_in;
	logic host_port_enable;
	logic [1:0] boot_mode_select;
	logic [2:0] clock_mode_pins;
	logic cfg_wr_toggle;
	logic [7:0] cfg_wr_byte;
	logic dev_hard_o;
	logic dev_hard_oe;
	logic dev_soft_o;
	logic dev_soft_oe;
	logic host_hard_o;
	logic host_hard_oe;
	logic host_soft_o;
	logic host_soft_oe;
	logic hard_reset_n;
	logic soft_reset_n;
	// Open-drain wires with a pull-up: any enabled low driver wins.
	assign hard_reset_n = ~((dev_hard_oe & ~dev_hard_o) | (host_hard_oe & ~host_hard_o));
	assign soft_reset_n = ~((dev_soft_oe & ~dev_soft_o) | (host_soft_oe & ~host_soft_o));
	modport dev (
		input power_on_reset_n, cfg_role_select, debug_request_in, host_port_enable, boot_mode_select,
		input clock_mode_pins, cfg_wr_toggle, cfg_wr_byte, hard_reset_n, soft_reset_n,
		output dev_hard_o, dev_hard_oe, dev_soft_o, dev_soft_oe
	);
	modport host (
		output power_on_reset_n, cfg_role_select, debug_request_in, host_port_enable, boot_mode_select,
		output clock_mode_pins, cfg_wr_toggle, cfg_wr_byte, host_hard_o, host_hard_oe, host_soft_o, host_soft_oe,
		input hard_reset_n, soft_reset_n
	);
endinterface : por_link_if

// ### src/por_sequencer.sv
// Device end: power-on reset flow, configuration capture and reset release sequencing.
`timescale 1ns/1ps
`include "por_consts.svh"
// Operation
// - Source holds power-on reset low 16 clocks.
// - Capture five strap inputs at reset rise.
// - Clock ratio from mode pins and word.
// - Role input low master, high slave.
// - Debug request high enters debug mode.
// - Host enable: host port, 32-bit, host word.
// - Boot mode 00 external, 01 host.
// - Configure 1024 clocks, then release, sample mode.
// - Halt until system PLL reports lock.
// - Enable internal clocks once PLL locked.
// - Delay loop locks 3073 clocks unless disabled.
// - Disabled delay loop skips lock phase.
// - Hard and soft reset held whole sequence.
// - Hard reset released 512 clocks after locking.
// - Soft reset released three clocks later.
// - Host mode extends internal reset until written.
// - Host writes word as four bytes.
// - Host writes after reset rise, before lock.
// - Host enable implies role input held high.
// - External resets seen only when not driving.
// - Reset pins driven open-drain only.
module por_sequencer
	import por_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	por_link_if.dev link,
	input wire logic pll_locked,
	input wire logic [31:0] hw_cfg_word,
	output logic int_por_n,
	output logic pll_start,
	output logic clocks_enable,
	output logic cfg_master,
	output logic debug_mode,
	output logic host_port_en,
	output logic bus_32bit,
	output logic [1:0] boot_src,
	output logic boot_reserved,
	output logic [6:0] clock_ratio,
	output logic [31:0] cfg_word,
	output logic core_hard_reset_n,
	output logic core_soft_reset_n,
	output logic ext_hard_seen,
	output logic ext_soft_seen
);
	dev_regs_t q;
	dev_regs_t n;
	logic por_s;
	logic role_s;
	logic dbg_s;
	logic hpe_s;
	logic [1:0] boot_s;
	logic [2:0] modck_s;
	logic hard_s;
	logic soft_s;
	logic tog_s;
	logic [7:0] byte_s;
	logic lock_s;
	logic [31:0] use_word;

	function automatic logic hit(input logic [11:0] cnt, input int limit);
		hit = (cnt == 12'(limit - 1));
	endfunction : hit

	// Every pin input passes two flops; lock comes from the PLL's domain too.
	assign {por_s, role_s, dbg_s, hpe_s, boot_s, modck_s, hard_s, soft_s, tog_s, byte_s, lock_s} = q.s2;
	assign use_word = q.cap_hpe ? q.word : hw_cfg_word;

	always_comb
	begin
		n = q;
		n.s1 = {link.power_on_reset_n, link.cfg_role_select, link.debug_request_in, link.host_port_enable,
			link.boot_mode_select, link.clock_mode_pins, link.hard_reset_n, link.soft_reset_n,
			link.cfg_wr_toggle, link.cfg_wr_byte, pll_locked};
		n.s2 = q.s1;
		n.por_prev = por_s;
		n.tog_prev = tog_s;
		if (q.cap_hpe && (q.state == S_CONFIG || q.state == S_HOST_WAIT) && tog_s != q.tog_prev
			&& !q.written)
		begin
			n.word = {q.word[23:0], byte_s};
			n.nbytes = q.nbytes + 3'h1;
			n.written = (q.nbytes == 3'(`CFG_BYTES - 1));
		end
		if (!por_s)
		begin
			n.state = S_POR;
			n.hard_drv = 1'b1;
			n.soft_drv = 1'b1;
			n.int_por_n = 1'b0;
			n.pll_start = 1'b0;
			n.clocks_enable = 1'b0;
			n.nbytes = 3'h0;
			n.written = 1'b0;
			n.cnt = 12'h000;
			n.ext_hard_seen = 1'b0;
			n.ext_soft_seen = 1'b0;
		end
		else
		begin
			unique case (q.state)
				S_POR:
				begin
					if (!q.por_prev)
					begin
						n.cap_role = role_s;
						n.cap_dbg = dbg_s;
						n.cap_hpe = hpe_s;
						n.cap_boot = boot_s;
						n.cnt = 12'h000;
						n.state = S_CONFIG;
					end
				end
				S_CONFIG:
				begin
					n.cnt = q.cnt + 12'h001;
					if (hit(q.cnt, `CFG_CYCLES))
					begin
						n.state = (q.cap_hpe && !q.written) ? S_HOST_WAIT : S_PLL_WAIT;
					end
				end
				S_HOST_WAIT:
				begin
					if (q.written)
					begin
						n.state = S_PLL_WAIT;
					end
				end
				S_PLL_WAIT:
				begin
					if (lock_s)
					begin
						n.clocks_enable = 1'b1;
						n.cnt = 12'h000;
						n.state = q.word[`DLL_DIS_BIT] ? S_HRST_HOLD : S_DLL_LOCK;
					end
				end
				S_DLL_LOCK:
				begin
					n.cnt = q.cnt + 12'h001;
					if (hit(q.cnt, `DLL_LOCK_CYCLES))
					begin
						n.cnt = 12'h000;
						n.state = S_HRST_HOLD;
					end
				end
				S_HRST_HOLD:
				begin
					n.cnt = q.cnt + 12'h001;
					if (hit(q.cnt, `HRST_EXTRA))
					begin
						n.hard_drv = 1'b0;
						n.cnt = 12'h000;
						n.state = S_SRST_HOLD;
					end
				end
				S_SRST_HOLD:
				begin
					n.cnt = q.cnt + 12'h001;
					if (hit(q.cnt, `SRST_LAG))
					begin
						n.soft_drv = 1'b0;
						n.cnt = 12'h000;
						n.state = S_RUN;
						n.debug_mode = q.cap_dbg;
						n.host_port_en = q.cap_hpe;
						n.bus_32bit = q.cap_hpe;
						n.boot_src = q.cap_boot;
						n.boot_reserved = q.cap_boot[1];
					end
				end
				S_RUN:
				begin
					// The synchronised pins lag our own drive, so a short grace hides our echo.
					if (q.cnt != 12'(`EXT_GRACE))
					begin
						n.cnt = q.cnt + 12'h001;
					end
					if (q.cnt == 12'(`EXT_GRACE) && !hard_s)
					begin
						n.ext_hard_seen = 1'b1;
					end
					if (q.cnt == 12'(`EXT_GRACE) && !soft_s && !q.soft_drv)
					begin
						n.ext_soft_seen = 1'b1;
					end
					// Soft follows the outside hard pull; the grace restarts so our own release is not echoed.
					n.soft_drv = !hard_s && (q.cnt == 12'(`EXT_GRACE) || q.soft_drv);
					if (q.soft_drv && !n.soft_drv)
					begin
						n.cnt = 12'h000;
					end
				end
			endcase
		end
		if (q.state != S_PLL_WAIT && n.state == S_PLL_WAIT)
		begin
			n.int_por_n = 1'b1;
			n.pll_start = 1'b1;
			n.word = use_word;
			n.clock_ratio = {use_word[`CLOCK_MODE_HIGH_FIELD_MSB:`CLOCK_MODE_HIGH_FIELD_LSB], modck_s};
			n.cfg_master = !q.cap_role;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.hard_drv <= 1'b1;
			q.soft_drv <= 1'b1;
		end
		else if (ce)
		begin
			q <= n;
		end
	end

	assign link.dev_hard_o = 1'b0;
	assign link.dev_soft_o = 1'b0;
	assign link.dev_hard_oe = q.hard_drv;
	assign link.dev_soft_oe = q.soft_drv;
	assign int_por_n = q.int_por_n;
	assign pll_start = q.pll_start;
	assign clocks_enable = q.clocks_enable;
	assign cfg_master = q.cfg_master;
	assign debug_mode = q.debug_mode;
	assign host_port_en = q.host_port_en;
	assign bus_32bit = q.bus_32bit;
	assign boot_src = q.boot_src;
	assign boot_reserved = q.boot_reserved;
	assign clock_ratio = q.clock_ratio;
	assign cfg_word = q.word;
	assign core_hard_reset_n = !q.hard_drv;
	assign core_soft_reset_n = !q.soft_drv;
	assign ext_hard_seen = q.ext_hard_seen;
	assign ext_soft_seen = q.ext_soft_seen;
endmodule : por_sequencer

// ### src/por_host.sv
// Host end: drives power-on reset and straps, writes the configuration word, under APB control.
`timescale 1ns/1ps
`include "por_consts.svh"
module por_host
	import por_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	por_link_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	host_regs_t q;
	host_regs_t n;
	logic wr;
	logic known;

	assign wr = psel && penable && q.pready && pwrite;
	assign known = paddr == `REG_CTRL || paddr == `REG_STRAP || paddr == `REG_WORD || paddr == `REG_STAT;

	always_comb
	begin
		n = q;
		n.s1 = {link.hard_reset_n, link.soft_reset_n};
		n.s2 = q.s1;
		n.pready = psel && !penable;
		n.pslverr = psel && !penable && !known;
		n.prdata = 32'h0;
		if (psel && !penable)
		begin
			unique case (paddr)
				`REG_CTRL: n.prdata = {29'h0, q.soft_req, q.hard_req, 1'b0};
				`REG_STRAP: n.prdata = {24'h0, q.strap};
				`REG_WORD: n.prdata = q.word;
				`REG_STAT: n.prdata = {28'h0, q.state != H_IDLE && q.state != H_DONE, q.done, q.s2};
				default: n.prdata = 32'h0;
			endcase
		end
		if (wr && paddr == `REG_CTRL)
		begin
			n.hard_req = pwdata[`CTRL_HARD];
			n.soft_req = pwdata[`CTRL_SOFT];
		end
		if (wr && paddr == `REG_STRAP)
		begin
			n.strap = pwdata[7:0];
		end
		if (wr && paddr == `REG_WORD)
		begin
			n.word = pwdata;
		end
		unique case (q.state)
			H_IDLE, H_DONE:
			begin
				if (wr && paddr == `REG_CTRL && pwdata[`CTRL_START])
				begin
					n.por_n = 1'b0;
					n.done = 1'b0;
					n.cnt = 4'h0;
					n.state = H_POR;
				end
			end
			H_POR:
			begin
				n.cnt = q.cnt + 4'h1;
				if (q.cnt == 4'(`POR_MIN_HOLD - 1))
				begin
					n.por_n = 1'b1;
					n.cnt = 4'h0;
					n.nbytes = 3'h0;
					n.state = q.strap[2] ? H_WRITE : H_DONE;
					n.done = !q.strap[2];
				end
			end
			H_WRITE:
			begin
				n.cnt = q.cnt + 4'h1;
				// The byte settles a cycle before its toggle so the far side never samples it moving.
				if (q.cnt == 4'h0)
				begin
					n.wr_byte = q.word[31 - 8 * q.nbytes -: 8];
				end
				if (q.cnt == 4'h1)
				begin
					n.tog = !q.tog;
				end
				if (q.cnt == 4'(`BYTE_GAP - 1))
				begin
					n.cnt = 4'h0;
					n.nbytes = q.nbytes + 3'h1;
					if (q.nbytes == 3'(`CFG_BYTES - 1))
					begin
						n.done = 1'b1;
						n.state = H_DONE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.strap <= `STRAP_RESET;
		end
		else if (ce)
		begin
			q <= n;
		end
	end

	assign link.power_on_reset_n = q.por_n;
	assign link.cfg_role_select = q.strap[0] | q.strap[2];
	assign link.debug_request_in = q.strap[1];
	assign link.host_port_enable = q.strap[2];
	assign link.boot_mode_select = q.strap[4:3];
	assign link.clock_mode_pins = q.strap[7:5];
	assign link.cfg_wr_toggle = q.tog;
	assign link.cfg_wr_byte = q.wr_byte;
	assign link.host_hard_o = 1'b0;
	assign link.host_soft_o = 1'b0;
	assign link.host_hard_oe = q.hard_req;
	assign link.host_soft_oe = q.soft_req;
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
endmodule : por_host

// ### verif/por_link_properties.sv
// Link-level properties of the power-on reset sequencer and its host end.
`timescale 1ns/1ps
module por_link_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_on_reset_n,
	input wire logic cfg_wr_toggle,
	input wire logic [7:0] cfg_wr_byte,
	input wire logic dev_hard_o,
	input wire logic dev_hard_oe,
	input wire logic dev_soft_o,
	input wire logic dev_soft_oe,
	input wire logic hard_reset_n,
	input wire logic soft_reset_n
);
	logic [4:0] low_q;
	logic [4:0] low_d;
	// Saturates so a long hold never wraps back to a short count.
	always_comb low_d = power_on_reset_n ? 5'h00 : ((low_q == 5'h1f) ? low_q : low_q + 5'h01);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			low_q <= 5'h00;
		else
			low_q <= low_d;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_POR_HOLD: assert property ($rose(power_on_reset_n) |-> low_q >= 5'h10)
		else $error("reset pulse short");
	AST_POR_PINS: assert property (!power_on_reset_n [*5] |-> !hard_reset_n && !soft_reset_n)
		else $error("pins not held");
	AST_SOFT_LAG: assert property ($fell(dev_hard_oe) |-> dev_soft_oe [*3] ##1 !dev_soft_oe)
		else $error("soft lag wrong");
	AST_SOFT_COVERS_HARD: assert property (dev_hard_oe |-> dev_soft_oe)
		else $error("soft released early");
	AST_OPEN_DRAIN: assert property (!dev_hard_o && !dev_soft_o && (!dev_hard_oe || !hard_reset_n)
		&& (!dev_soft_oe || !soft_reset_n))
		else $error("pin drive wrong");
	AST_EXT_HARD: assert property (!hard_reset_n [*6] |-> !soft_reset_n)
		else $error("soft not with hard");
	AST_BYTE_GAP: assert property ($changed(cfg_wr_toggle) |=> $stable(cfg_wr_toggle) [*3])
		else $error("bytes too close");
	AST_BYTE_SETUP: assert property ($changed(cfg_wr_toggle) |-> $stable(cfg_wr_byte))
		else $error("byte not settled");
	AST_BYTE_AFTER_POR: assert property ($changed(cfg_wr_toggle) |-> power_on_reset_n)
		else $error("byte during reset");
	C_HARD_RELEASE: cover property ($fell(dev_hard_oe));
	C_BYTE: cover property ($changed(cfg_wr_toggle));
	C_EXT_HARD: cover property (!hard_reset_n && !dev_hard_oe);
endmodule : por_link_properties

// ### verif/tb.sv
// Testbench driving both ends of the power-on reset link.
`timescale 1ns/1ps
`include "por_consts.svh"
module tb;
	typedef struct {logic [7:0] strap; logic [31:0] word; int hold;} row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic pll_locked = 1'b0;
	logic host_ce = 1'b1;
	logic [31:0] hw_cfg_word = 32'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, cfg_word, rd;
	logic pready, pslverr, int_por_n, pll_start, clocks_enable, cfg_master, debug_mode, host_port_en, bus_32bit;
	logic boot_reserved, core_hard_reset_n, core_soft_reset_n, ext_hard_seen, ext_soft_seen, er;
	logic [1:0] boot_src;
	logic [6:0] clock_ratio;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	// Strap byte is {clock mode, boot, host enable, debug, role}; last row is host mode with role high.
	row_t rows [5] = '{'{8'ha2, 32'h3000_0000, 3585}, '{8'h49, 32'hc000_0001, 512},
		'{8'hf0, 32'h5000_0001, 512}, '{8'h1b, 32'ha000_0001, 512}, '{8'h6d, 32'h9abc_de01, 512}};
	always #10 pclk = ~pclk;
	por_link_if por_link_if_inst ();
	por_sequencer por_sequencer_inst (.pclk, .presetn, .ce(1'b1), .link(por_link_if_inst), .pll_locked,
		.hw_cfg_word, .int_por_n, .pll_start, .clocks_enable, .cfg_master, .debug_mode, .host_port_en, .bus_32bit,
		.boot_src, .boot_reserved, .clock_ratio, .cfg_word, .core_hard_reset_n, .core_soft_reset_n,
		.ext_hard_seen, .ext_soft_seen);
	por_host por_host_inst (.pclk, .presetn, .ce(host_ce), .link(por_link_if_inst), .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
	por_link_properties por_link_properties_inst (.pclk, .presetn,
		.power_on_reset_n(por_link_if_inst.power_on_reset_n), .cfg_wr_toggle(por_link_if_inst.cfg_wr_toggle),
		.cfg_wr_byte(por_link_if_inst.cfg_wr_byte), .dev_hard_o(por_link_if_inst.dev_hard_o),
		.dev_hard_oe(por_link_if_inst.dev_hard_oe), .dev_soft_o(por_link_if_inst.dev_soft_o),
		.dev_soft_oe(por_link_if_inst.dev_soft_oe), .hard_reset_n(por_link_if_inst.hard_reset_n),
		.soft_reset_n(por_link_if_inst.soft_reset_n));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task give_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task flow(input row_t r);
		// A wrong word choice in host mode would flip the delay-loop bit and the hold count.
		hw_cfg_word <= r.strap[2] ? ~r.word : r.word;
		pll_locked <= 1'b0;
		apb(1'b1, `REG_WORD, r.word);
		apb(1'b1, `REG_STRAP, {24'h0, r.strap});
		apb(1'b1, `REG_CTRL, 32'h1);
		while (por_link_if_inst.power_on_reset_n !== 1'b0)
			@(posedge pclk);
		while (por_link_if_inst.power_on_reset_n !== 1'b1)
			@(posedge pclk);
		n = 0;
		while (pll_start !== 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		chk("config length", n >= 1024 && n <= 1028, 1);
		chk("internal reset", int_por_n, 1);
		repeat (50) @(posedge pclk);
		chk("clocks before lock", clocks_enable, 0);
		chk("hard before lock", por_link_if_inst.hard_reset_n, 0);
		pll_locked <= 1'b1;
		while (clocks_enable !== 1'b1)
			@(posedge pclk);
		n = 0;
		while (por_link_if_inst.hard_reset_n !== 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		chk("hard hold", n, r.hold);
		n = 0;
		while (por_link_if_inst.soft_reset_n !== 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		chk("soft lag", n, 3);
		repeat (2) @(posedge pclk);
		chk("clocks on", clocks_enable, 1);
		chk("role", cfg_master, !r.strap[0]);
		chk("debug", debug_mode, r.strap[1]);
		chk("host port", {host_port_en, bus_32bit}, {2{r.strap[2]}});
		chk("boot", {boot_reserved, boot_src}, {r.strap[4], r.strap[4:3]});
		chk("ratio", clock_ratio, {r.word[31:28], r.strap[7:5]});
		chk("word", cfg_word, r.word);
	endtask : flow
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			give_verdict;
		end
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
			flow(rows[i]);
		apb(1'b0, `REG_STAT, 32'h0);
		chk("status", rd, 32'h7);
		apb(1'b0, `REG_WORD, 32'h0);
		chk("word readback", rd, rows[4].word);
		apb(1'b0, `REG_STRAP, 32'h0);
		chk("strap readback", rd, {24'h0, rows[4].strap});
		apb(1'b1, `REG_CTRL, 32'h2);
		repeat (10) @(posedge pclk);
		chk("ext hard soft pin", por_link_if_inst.soft_reset_n, 0);
		chk("ext hard seen", ext_hard_seen, 1);
		apb(1'b1, `REG_CTRL, 32'h4);
		repeat (10) @(posedge pclk);
		chk("ext soft seen", ext_soft_seen, 1);
		apb(1'b1, `REG_CTRL, 32'h0);
		repeat (10) @(posedge pclk);
		chk("soft back", por_link_if_inst.soft_reset_n, 1);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", er, 1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, `REG_CTRL, 32'h1);
		while (por_link_if_inst.power_on_reset_n !== 1'b0)
			@(posedge pclk);
		while (por_link_if_inst.power_on_reset_n !== 1'b1)
			@(posedge pclk);
		// Freezing the host after the rise holds the word back past the configuration count.
		host_ce <= 1'b0;
		repeat (1100) @(posedge pclk);
		chk("host wait", int_por_n, 0);
		host_ce <= 1'b1;
		repeat (40) @(posedge pclk);
		chk("host written", int_por_n, 1);
		chk("late word", cfg_word, rows[4].word);
		repeat (100) @(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("reset hard", por_link_if_inst.hard_reset_n, 0);
		chk("reset internal", int_por_n, 0);
		presetn <= 1'b1;
		flow(rows[1]);
		give_verdict;
	end
endmodule : tb
